/* fecl_consts.vh */
// fecl_consts.vh: offsets, field positions, reset values and command codes
// assumes: included by bare name into the flash capture and launch top
`ifndef FECL_CONSTS_VH
`define FECL_CONSTS_VH

// ****************************************************************
// register offsets (8-bit address, one per 16-bit register on the register port)
// ****************************************************************
`define FECL_OFS_CLKDIV 8'h00
`define FECL_OFS_PIDX 8'h01
`define FECL_OFS_EIDX 8'h02
`define FECL_OFS_STAT 8'h03
`define FECL_OFS_ECCFLG 8'h04
`define FECL_OFS_PBUF 8'h05
`define FECL_OFS_EWIN 8'h06
`define FECL_OFS_OPT 8'h07
`define FECL_OFS_RSV1 8'h08
`define FECL_OFS_RSV2 8'h09
`define FECL_OFS_RSV3 8'h0A
`define FECL_OFS_RSV4 8'h0B

// ****************************************************************
// field positions
// ****************************************************************
`define FECL_BIT_DIVLD 7
`define FECL_BIT_COMMAND_COMPLETE_FLAG 7
`define FECL_BIT_ACCESS_ERROR_FLAG 5
`define FECL_BIT_PVIOL 4
`define FECL_BIT_DBE 1
`define FECL_BIT_SBE 0

// ****************************************************************
// reset values and sizes
// ****************************************************************
`define FECL_RST_DIV 7'h00
`define FECL_RST_IDX 3'h0
`define FECL_RST_WORD 16'h0000
`define FECL_RST_OPT 8'h00
`define FECL_OPT_DBE_FILL 8'hFF
`define FECL_PBUF_WORDS 6
`define FECL_EIDX_PAR 3'h0
`define FECL_EIDX_ADDR 3'h1
`define FECL_EIDX_D0 3'h2
`define FECL_EIDX_D1 3'h3
`define FECL_EIDX_D2 3'h4
`define FECL_EIDX_D3 3'h5

// ****************************************************************
// program and erase command codes
// ****************************************************************
`define FECL_CMD_PGM_P 8'h06
`define FECL_CMD_PGM_ONCE 8'h07
`define FECL_CMD_ERS_ALL 8'h08
`define FECL_CMD_ERS_BLK 8'h09
`define FECL_CMD_ERS_PSEC 8'h0A
`define FECL_CMD_UNSECURE 8'h0B
`define FECL_CMD_PGM_D 8'h11
`define FECL_CMD_ERS_DSEC 8'h12

`endif

/* fecl_timebase.v */
// fecl_timebase.v: divider giving the program/erase time base tick
// assumes: synchronous reset copy from the top, one clock domain
`timescale 1ns/1ps

module fecl_timebase (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // control
  input wire divider_loaded_flag,
  input wire [6:0] timebase_divide_value,
  // time base
  output reg program_erase_timebase
);

  reg [6:0] cnt_reg; // cycles left in this period

  // ****************************************************************
  // tick once every divide value plus one cycles
  // ****************************************************************
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 7'h00;
      program_erase_timebase <= 1'b0;
    end else if (!divider_loaded_flag) begin
      // no time base before software sets the divider
      cnt_reg <= 7'h00;
      program_erase_timebase <= 1'b0;
    end else if (cnt_reg == 7'h00) begin
      cnt_reg <= timebase_divide_value;
      program_erase_timebase <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg - 7'h01;
      program_erase_timebase <= 1'b0;
    end
  end

endmodule

/* fecl_top.v */
// fecl_top.v: ecc fault capture, option byte, reserved registers,
// divider gate and command launch handshake of the flash controller
// assumes: command engine and flash array on clk_sys, no crossings
//
// Functional notes
// - reserved registers read zero, ignore writes
// - capture frozen until its fault flag clears
// - simultaneous faults record the double-bit one
// - result window shows item chosen by index
// - unused result indices read all zero
// - index zero high byte holds check bits
// - index zero low bits hold upper address
// - program faults give four raw words
// - data faults give raw word, low address
// - result window is read-only
// - option register loaded during reset sequence
// - double fault on option load sets all ones
// - option register readable, writes ignored
// - divider write sets divider-loaded flag
// - no divider: refuse program/erase, access error
// - while busy refuse launch and buffer writes
// - write one to complete flag launches command
// - command code in high byte, word zero
// - unimplemented buffer words ignore writes, read zero
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
`include "fecl_consts.vh"

module fecl_top (
  // clock and reset
  input wire clk_sys,
  input wire rstn,
  // register port
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // ecc fault report from the array read path
  input wire ecc_single_evt,
  input wire ecc_double_evt,
  input wire ecc_is_program_array,
  input wire [22:0] ecc_fault_addr,
  input wire [7:0] ecc_fault_check_bits,
  input wire [15:0] ecc_fault_data0,
  input wire [15:0] ecc_fault_data1,
  input wire [15:0] ecc_fault_data2,
  input wire [15:0] ecc_fault_data3,
  // option byte fetch of the reset sequence
  input wire opt_fetch_valid,
  input wire [7:0] opt_fetch_data,
  input wire opt_fetch_double_fault,
  // command engine
  input wire cmd_done,
  input wire cmd_access_error,
  input wire cmd_protection_violation,
  input wire cmd_result_wr,
  input wire [2:0] cmd_result_idx,
  input wire [15:0] cmd_result_data,
  output reg cmd_start,
  output wire [95:0] cmd_params,
  // status towards the rest of the chip
  output reg [7:0] option_bits,
  output reg divider_loaded_flag,
  output reg command_complete_flag,
  output wire program_erase_timebase
);

  // ****************************************************************
  // reset release
  // ****************************************************************
  reg rst_meta_reg; // first stage of reset release
  reg rst_n; // released reset used everywhere

  // two-stage release, assert asynchronously
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // ****************************************************************
  // state
  // ****************************************************************
  reg [6:0] div_reg; // timebase_divide_value
  reg [2:0] pidx_reg; // parameter_word_index
  reg [2:0] eidx_reg; // ecc_result_index
  reg access_error_flag_reg; // access_error_flag
  reg pviol_reg; // protection_violation_flag
  reg sbe_reg; // single-bit fault flag
  reg dbe_reg; // double-bit fault flag
  reg init_reg; // reset sequence still fetching option byte
  reg [7:0] cap_par_reg; // captured_check_bits
  reg [6:0] cap_hi_reg; // fault_upper_address
  reg [15:0] cap_lo_reg; // lower fault address
  reg [15:0] cap_d0_reg; // raw data word 0
  reg [15:0] cap_d1_reg; // raw data word 1
  reg [15:0] cap_d2_reg; // raw data word 2
  reg [15:0] cap_d3_reg; // raw data word 3
  reg [15:0] pbuf_reg [0:5]; // command_parameter_buffer

  // ****************************************************************
  // register decode
  // ****************************************************************
  wire wr_div = reg_wr && (reg_addr == `FECL_OFS_CLKDIV);
  wire wr_pidx = reg_wr && (reg_addr == `FECL_OFS_PIDX);
  wire wr_eidx = reg_wr && (reg_addr == `FECL_OFS_EIDX);
  wire wr_stat = reg_wr && (reg_addr == `FECL_OFS_STAT);
  wire wr_eflg = reg_wr && (reg_addr == `FECL_OFS_ECCFLG);
  wire wr_pbuf = reg_wr && (reg_addr == `FECL_OFS_PBUF);

  // ****************************************************************
  // launch decision
  // ****************************************************************
  wire [7:0] cmd_code = pbuf_reg[0][15:8]; // command_code
  reg is_pgm_ers; // launched code programs or erases

  // classify program and erase command codes
  always @* begin
    case (cmd_code)
      `FECL_CMD_PGM_P,
      `FECL_CMD_PGM_ONCE,
      `FECL_CMD_ERS_ALL,
      `FECL_CMD_ERS_BLK,
      `FECL_CMD_ERS_PSEC,
      `FECL_CMD_UNSECURE,
      `FECL_CMD_PGM_D,
      `FECL_CMD_ERS_DSEC: is_pgm_ers = 1'b1;
      default: is_pgm_ers = 1'b0;
    endcase
  end

  // launch only when idle, out of reset fetch, errors clear
  wire launch_req = wr_stat && reg_wdata[`FECL_BIT_COMMAND_COMPLETE_FLAG] && command_complete_flag &&
                    !init_reg && !access_error_flag_reg && !pviol_reg;
  // program/erase without a divider never runs
  wire launch_block = launch_req && is_pgm_ers && !divider_loaded_flag;
  wire launch_go = launch_req && !launch_block;

  // ****************************************************************
  // option byte and reset sequence
  // ****************************************************************
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      init_reg <= 1'b1;
      option_bits <= `FECL_RST_OPT;
    end else if (init_reg && opt_fetch_valid) begin
      init_reg <= 1'b0;
      // double fault leaves every bit set
      if (opt_fetch_double_fault) begin
        option_bits <= `FECL_OPT_DBE_FILL;
      end else begin
        option_bits <= opt_fetch_data;
      end
    end
  end

  // ****************************************************************
  // divider and index registers
  // ****************************************************************
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= `FECL_RST_DIV;
      divider_loaded_flag <= 1'b0;
      pidx_reg <= `FECL_RST_IDX;
      eidx_reg <= `FECL_RST_IDX;
    end else begin
      if (wr_div) begin
        div_reg <= reg_wdata[6:0];
        divider_loaded_flag <= 1'b1; // any write marks it loaded
      end
      if (wr_pidx) begin
        pidx_reg <= reg_wdata[2:0];
      end
      if (wr_eidx) begin
        eidx_reg <= reg_wdata[2:0];
      end
    end
  end

  // ****************************************************************
  // status flags and launch handshake
  // ****************************************************************
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      command_complete_flag <= 1'b1;
      cmd_start <= 1'b0;
      access_error_flag_reg <= 1'b0;
      pviol_reg <= 1'b0;
    end else begin
      cmd_start <= launch_go;
      // writing one clears the flag and hands over the buffer
      if (launch_go) begin
        command_complete_flag <= 1'b0;
      end else if (!command_complete_flag && cmd_done) begin
        command_complete_flag <= 1'b1;
      end
      // error flags: set wins over a write-one clear
      if (launch_block || (cmd_done && cmd_access_error)) begin
        access_error_flag_reg <= 1'b1;
      end else if (wr_stat && reg_wdata[`FECL_BIT_ACCESS_ERROR_FLAG]) begin
        access_error_flag_reg <= 1'b0;
      end
      if (cmd_done && cmd_protection_violation) begin
        pviol_reg <= 1'b1;
      end else if (wr_stat && reg_wdata[`FECL_BIT_PVIOL]) begin
        pviol_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // command parameter buffer, one slice per word
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < `FECL_PBUF_WORDS; gi = gi + 1) begin : g_pbuf
      // software writes only while idle, engine results only while busy
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          pbuf_reg[gi] <= `FECL_RST_WORD;
        end else if (command_complete_flag) begin
          if (wr_pbuf && (pidx_reg == gi)) begin
            pbuf_reg[gi] <= reg_wdata;
          end
        end else if (cmd_result_wr && (cmd_result_idx == gi)) begin
          pbuf_reg[gi] <= cmd_result_data; // results returned
        end
      end
      assign cmd_params[16*gi+15:16*gi] = pbuf_reg[gi];
    end
  endgenerate

  // ****************************************************************
  // ecc fault capture
  // ****************************************************************
  // flags left after this cycle's clear; set still wins the same cycle
  wire sbe_keep = sbe_reg && !(wr_eflg && reg_wdata[`FECL_BIT_SBE]);
  wire dbe_keep = dbe_reg && !(wr_eflg && reg_wdata[`FECL_BIT_DBE]);
  wire ecc_evt = ecc_single_evt || ecc_double_evt;
  // record only while no flag holds earlier information
  wire ecc_take = ecc_evt && !sbe_keep && !dbe_keep;

  // fault flags, double over single
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sbe_reg <= 1'b0;
      dbe_reg <= 1'b0;
    end else if (ecc_take) begin
      dbe_reg <= ecc_double_evt;
      sbe_reg <= !ecc_double_evt;
    end else begin
      sbe_reg <= sbe_keep;
      dbe_reg <= dbe_keep;
    end
  end

  // captured contents, frozen while a flag stands
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cap_par_reg <= 8'h00;
      cap_hi_reg <= 7'h00;
      cap_lo_reg <= `FECL_RST_WORD;
      cap_d0_reg <= `FECL_RST_WORD;
      cap_d1_reg <= `FECL_RST_WORD;
      cap_d2_reg <= `FECL_RST_WORD;
      cap_d3_reg <= `FECL_RST_WORD;
    end else if (ecc_take) begin
      cap_hi_reg <= ecc_fault_addr[22:16];
      cap_lo_reg <= ecc_fault_addr[15:0];
      cap_d0_reg <= ecc_fault_data0; // raw, uncorrected
      if (ecc_is_program_array) begin
        cap_par_reg <= ecc_fault_check_bits; // eight check bits
        cap_d1_reg <= ecc_fault_data1;
        cap_d2_reg <= ecc_fault_data2;
        cap_d3_reg <= ecc_fault_data3;
      end else begin
        // data array: six check bits, top two zero
        cap_par_reg <= {2'b00, ecc_fault_check_bits[5:0]};
        cap_d1_reg <= `FECL_RST_WORD;
        cap_d2_reg <= `FECL_RST_WORD;
        cap_d3_reg <= `FECL_RST_WORD;
      end
    end
  end

  // ****************************************************************
  // read data paths
  // ****************************************************************
  reg [15:0] ewin; // ecc_fault_result_window, no write path
  reg [15:0] pbuf_rd; // selected buffer word
  reg [15:0] rd_next; // read mux

  // result window selection
  always @* begin
    case (eidx_reg)
      `FECL_EIDX_PAR: ewin = {cap_par_reg, 1'b0, cap_hi_reg};
      `FECL_EIDX_ADDR: ewin = cap_lo_reg;
      `FECL_EIDX_D0: ewin = cap_d0_reg;
      `FECL_EIDX_D1: ewin = cap_d1_reg;
      `FECL_EIDX_D2: ewin = cap_d2_reg;
      `FECL_EIDX_D3: ewin = cap_d3_reg;
      default: ewin = `FECL_RST_WORD; // unused positions
    endcase
  end

  // unimplemented buffer words read zero
  always @* begin
    if (pidx_reg < `FECL_PBUF_WORDS) begin
      pbuf_rd = pbuf_reg[pidx_reg];
    end else begin
      pbuf_rd = `FECL_RST_WORD;
    end
  end

  // register read mux, unmapped reads zero
  always @* begin
    rd_next = `FECL_RST_WORD;
    case (reg_addr)
      `FECL_OFS_CLKDIV: rd_next = {8'h00, divider_loaded_flag, div_reg};
      `FECL_OFS_PIDX: rd_next = {13'h0000, pidx_reg};
      `FECL_OFS_EIDX: rd_next = {13'h0000, eidx_reg};
      `FECL_OFS_STAT: begin
        rd_next[`FECL_BIT_COMMAND_COMPLETE_FLAG] = command_complete_flag && !init_reg;
        rd_next[`FECL_BIT_ACCESS_ERROR_FLAG] = access_error_flag_reg;
        rd_next[`FECL_BIT_PVIOL] = pviol_reg;
      end
      `FECL_OFS_ECCFLG: begin
        rd_next[`FECL_BIT_DBE] = dbe_reg;
        rd_next[`FECL_BIT_SBE] = sbe_reg;
      end
      `FECL_OFS_PBUF: rd_next = pbuf_rd;
      `FECL_OFS_EWIN: rd_next = ewin;
      `FECL_OFS_OPT: rd_next = {8'h00, option_bits}; // read-only
      `FECL_OFS_RSV1,
      `FECL_OFS_RSV2,
      `FECL_OFS_RSV3,
      `FECL_OFS_RSV4: rd_next = `FECL_RST_WORD; // no storage
      default: rd_next = `FECL_RST_WORD;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `FECL_RST_WORD;
    end else if (reg_rd) begin
      reg_rdata <= rd_next;
    end else begin
      reg_rdata <= `FECL_RST_WORD;
    end
  end

  // ****************************************************************
  // program/erase time base
  // ****************************************************************
  fecl_timebase u_timebase (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .divider_loaded_flag(divider_loaded_flag),
    .timebase_divide_value(div_reg),
    .program_erase_timebase(program_erase_timebase)
  );

endmodule

/* fecl_checker_assertions.sv */
// fecl_checker_assertions.sv: port-level checks of the flash capture/launch top
// assumes: bound to fecl_top, single clock domain, rstn active low
`timescale 1ns/1ps

module fecl_checker (
  // clock and reset
  input wire clk_sys,
  input wire rstn,
  // register port
  input wire [7:0] reg_addr,
  input wire reg_rd,
  input wire reg_wr,
  input wire [15:0] reg_rdata,
  // option fetch
  input wire opt_fetch_valid,
  input wire [7:0] opt_fetch_data,
  input wire opt_fetch_double_fault,
  // command engine side
  input wire cmd_done,
  input wire cmd_result_wr,
  input wire cmd_start,
  input wire [95:0] cmd_params,
  input wire [7:0] option_bits,
  input wire divider_loaded_flag,
  input wire command_complete_flag
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_rsv_read_zero: assert property (reg_rd && reg_addr >= 8'h08 && reg_addr <= 8'h0B
    |=> reg_rdata == 16'h0000) else $error("reserved read not zero");
  a_opt_read_back: assert property (reg_rd && reg_addr == 8'h07
    |=> reg_rdata == {8'h00, $past(option_bits)}) else $error("option read wrong");
  a_opt_load_byte: assert property (opt_fetch_valid && !opt_fetch_double_fault
    |=> option_bits == $past(opt_fetch_data)) else $error("option byte not loaded");
  a_opt_fill_ones: assert property (opt_fetch_valid && opt_fetch_double_fault
    |=> option_bits == 8'hFF) else $error("option not all ones");
  a_opt_hold_val: assert property (!opt_fetch_valid |=> $stable(option_bits))
    else $error("option changed without fetch");
  a_div_flag_set: assert property (reg_wr && reg_addr == 8'h00
    |=> divider_loaded_flag) else $error("divider flag not set");
  a_start_cause: assert property (cmd_start |-> !command_complete_flag
    && $past(reg_wr) && $past(reg_addr) == 8'h03) else $error("start without launch");
  a_done_returns: assert property (!command_complete_flag && cmd_done
    |=> command_complete_flag) else $error("complete flag not back");
  a_no_div_gate: assert property (cmd_start && !divider_loaded_flag
    |-> !(cmd_params[15:8] inside {8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h11, 8'h12}))
    else $error("program or erase ran without divider");
  a_params_lock: assert property (!command_complete_flag && !cmd_result_wr
    |=> $stable(cmd_params)) else $error("buffer changed while busy");
endmodule

bind fecl_top fecl_checker chk_i (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .opt_fetch_valid(opt_fetch_valid),
  .opt_fetch_data(opt_fetch_data), .opt_fetch_double_fault(opt_fetch_double_fault),
  .cmd_done(cmd_done), .cmd_result_wr(cmd_result_wr), .cmd_start(cmd_start),
  .cmd_params(cmd_params), .option_bits(option_bits),
  .divider_loaded_flag(divider_loaded_flag), .command_complete_flag(command_complete_flag));

/* fecl_tb.sv */
// fecl_tb.sv: self-checking bench of the flash capture/launch top
// assumes: register port with read data one cycle after the strobe
`timescale 1ns/1ps

module tb_top;
  // ****************************************************************
  // stimulus and observed signals
  // ****************************************************************
  reg clk_sys = 0;
  reg rstn = 0;
  reg [7:0] reg_addr = 0;
  reg [15:0] reg_wdata = 0;
  reg reg_wr = 0, reg_rd = 0;
  reg es = 0, ed = 0, epa = 0;
  reg [22:0] ead = 0;
  reg [7:0] epb = 0, ofd = 0;
  reg [15:0] fd0 = 0, fd1 = 0, fd2 = 0, fd3 = 0, rdat = 0;
  reg ofv = 0, ofx = 0, done = 0, acc = 0, pvi = 0, rwr = 0;
  reg [2:0] ridx = 0;
  wire [15:0] reg_rdata;
  wire [7:0] option_bits;
  wire cmd_start, divider_loaded_flag, command_complete_flag;
  wire tick; // program/erase time base pulse
  integer errors = 0, comparisons = 0, cycles = 0, starts = 0, ticks = 0, t0, i;
  reg [15:0] rows [0:31]; // write addr, write data, read addr, expected

  fecl_top dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ecc_single_evt(es),
    .ecc_double_evt(ed), .ecc_is_program_array(epa), .ecc_fault_addr(ead),
    .ecc_fault_check_bits(epb), .ecc_fault_data0(fd0), .ecc_fault_data1(fd1),
    .ecc_fault_data2(fd2), .ecc_fault_data3(fd3), .opt_fetch_valid(ofv),
    .opt_fetch_data(ofd), .opt_fetch_double_fault(ofx), .cmd_done(done),
    .cmd_access_error(acc), .cmd_protection_violation(pvi), .cmd_result_wr(rwr),
    .cmd_result_idx(ridx), .cmd_result_data(rdat), .cmd_start(cmd_start), .cmd_params(),
    .option_bits(option_bits), .divider_loaded_flag(divider_loaded_flag),
    .command_complete_flag(command_complete_flag), .program_erase_timebase(tick));

  // clock, launch counter and hang guard
  always #5 clk_sys = ~clk_sys; // 100 MHz, far above the bus clock floor
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cmd_start === 1'b1) starts <= starts + 1;
    if (tick === 1'b1) ticks <= ticks + 1;
    if (cycles == 6000) begin
      errors = errors + 1;
      complete_run;
    end
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task chk(input [15:0] got, input [15:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("BAD %0t saw %h want %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    begin
      reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 0;
      @(posedge clk_sys);
    end
  endtask
  task rd(input [7:0] a, input [15:0] e);
    begin
      reg_rd <= 1; reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 0;
      #1 chk(reg_rdata, e);
      @(posedge clk_sys);
    end
  endtask
  // reset, then option fetch with or without a double fault
  task do_reset(input dbl);
    begin
      rstn <= 0;
      repeat (5) @(posedge clk_sys);
      rstn <= 1;
      repeat (3) @(posedge clk_sys);
      ofv <= 1; ofd <= 8'h5A; ofx <= dbl;
      @(posedge clk_sys);
      ofv <= 0;
      @(posedge clk_sys);
    end
  endtask
  // one fault event; data words derived from b
  task ev(input s, input d, input pa, input [22:0] ad, input [7:0] pb, input [15:0] b);
    begin
      es <= s; ed <= d; epa <= pa; ead <= ad; epb <= pb;
      fd0 <= b; fd1 <= b + 1; fd2 <= b + 2; fd3 <= b + 3;
      @(posedge clk_sys);
      es <= 0; ed <= 0;
      @(posedge clk_sys);
    end
  endtask
  // walk all eight result indices
  task win(input pa, input [22:0] ad, input [7:0] pb, input [15:0] b);
    reg [15:0] e;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        e = (i == 0) ? {pa ? pb : {2'b00, pb[5:0]}, 1'b0, ad[22:16]} :
            (i == 1) ? ad[15:0] : (i == 2) ? b :
            (i < 6 && pa) ? b + i[15:0] - 16'h0002 : 16'h0000;
        wr(8'h02, i[15:0]);
        rd(8'h06, e);
      end
    end
  endtask
  task complete_run;
    begin
      if (errors == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    rows[0] = 16'h08; rows[1] = 16'hFFFF; rows[2] = 16'h08; rows[3] = 16'h0000;
    rows[4] = 16'h09; rows[5] = 16'h5555; rows[6] = 16'h09; rows[7] = 16'h0000;
    rows[8] = 16'h0A; rows[9] = 16'hAAAA; rows[10] = 16'h0A; rows[11] = 16'h0000;
    rows[12] = 16'h0B; rows[13] = 16'h00FF; rows[14] = 16'h0B; rows[15] = 16'h0000;
    rows[16] = 16'h07; rows[17] = 16'h00A5; rows[18] = 16'h07; rows[19] = 16'h005A;
    rows[20] = 16'h01; rows[21] = 16'h0006; rows[22] = 16'h05; rows[23] = 16'h0000;
    rows[24] = 16'h05; rows[25] = 16'h1234; rows[26] = 16'h05; rows[27] = 16'h0000;
    rows[28] = 16'h01; rows[29] = 16'h0000; rows[30] = 16'h05; rows[31] = 16'h0000;
    do_reset(0);
    chk(option_bits, 16'h005A);
    for (i = 0; i < 8; i = i + 1) begin
      wr(rows[4*i][7:0], rows[4*i+1]);
      rd(rows[4*i+2][7:0], rows[4*i+3]);
    end
    // non-program code runs without a divider, engine finishes it
    wr(8'h03, 16'h0080);
    chk(ticks, 16'h0000); // no time base before the divider
    done <= 1;
    @(posedge clk_sys);
    done <= 0;
    @(posedge clk_sys);
    rd(8'h03, 16'h0080);
    chk(starts, 16'h0001);
    // program code without divider: refused with access error
    wr(8'h05, 16'h0600); // parameters loaded while idle
    chk(divider_loaded_flag, 16'h0000);
    wr(8'h03, 16'h0080);
    rd(8'h03, 16'h00A0);
    chk(starts, 16'h0001);
    wr(8'h03, 16'h0020);
    wr(8'h00, 16'h0005); // divider before any program/erase
    rd(8'h00, 16'h0085);
    wr(8'h03, 16'h0080);
    #1 chk(starts, 16'h0002);
    chk(command_complete_flag, 16'h0000);
    @(posedge clk_sys);
    wr(8'h05, 16'hFFFF);
    // engine returns a result, software stays off the registers
    rwr <= 1; ridx <= 3'h1; rdat <= 16'hBEEF;
    @(posedge clk_sys);
    rwr <= 0; done <= 1; pvi <= 1;
    @(posedge clk_sys);
    done <= 0; pvi <= 0;
    @(posedge clk_sys);
    #1 chk(command_complete_flag, 16'h0001);
    @(posedge clk_sys);
    rd(8'h05, 16'h0600);
    wr(8'h01, 16'h0001);
    rd(8'h05, 16'hBEEF);
    rd(8'h03, 16'h0090);
    wr(8'h03, 16'h0080);
    #1 chk(starts, 16'h0002);
    @(posedge clk_sys);
    wr(8'h03, 16'h0010);
    // fault capture, freeze, read-only window, priority
    ev(1, 0, 1, 23'h7F1234, 8'hA5, 16'h1000);
    rd(8'h04, 16'h0001);
    ev(0, 1, 0, 23'h100ABC, 8'h3C, 16'h7777);
    wr(8'h06, 16'hFFFF);
    win(1, 23'h7F1234, 8'hA5, 16'h1000);
    wr(8'h04, 16'h0003);
    ev(1, 1, 0, 23'h100ABC, 8'hFF, 16'h2222);
    rd(8'h04, 16'h0002);
    win(0, 23'h100ABC, 8'hFF, 16'h2222);
    // clear and new fault in one cycle: the new fault is recorded
    fork
      wr(8'h04, 16'h0002);
      ev(1, 0, 1, 23'h012345, 8'h81, 16'h4444);
    join
    rd(8'h04, 16'h0001);
    wr(8'h02, 16'h0001);
    rd(8'h06, 16'h2345);
    // time base pulses once every divide value plus one cycles
    t0 = ticks;
    repeat (60) @(posedge clk_sys);
    chk(ticks - t0, 16'h000A);
    // second reset, option fetch with a double fault
    do_reset(1);
    rd(8'h07, 16'h00FF);
    complete_run;
  end
endmodule
